/* logic/siom_defs.vh */
// constants for the servo i/o function mapping block
`ifndef SIOM_DEFS_VH
`define SIOM_DEFS_VH

// register byte offsets
`define SIOM_OFS_OUT1_SEL     12'h000
`define SIOM_OFS_OUT2_SEL     12'h004
`define SIOM_OFS_OUT3_SEL     12'h008
`define SIOM_OFS_OUT_STATUS   12'h00c
`define SIOM_OFS_FORCE_MASK   12'h010
`define SIOM_OFS_OUT1_POL     12'h014
`define SIOM_OFS_OUT2_POL     12'h018
`define SIOM_OFS_OUT3_POL     12'h01c
`define SIOM_OFS_FORCE_CTRL   12'h020
`define SIOM_OFS_IN_STATUS    12'h024
`define SIOM_OFS_IN_CODE_BASE 12'h040
`define SIOM_OFS_IN_CODE_LAST 12'h064

// widths and counts
`define SIOM_SEL_W        7
`define SIOM_SEL_MAX      7'h63
`define SIOM_OUT_FUNCS    100
`define SIOM_OUT_SEL_N    3
`define SIOM_OUT_N        6
`define SIOM_IN_N         10
`define SIOM_CODE_W       5
`define SIOM_FUNC_N       24
`define SIOM_IDX_W        4
`define SIOM_ALIGN_W      2
`define SIOM_FLAG_BIT     0
`define SIOM_SEL_NONE     7'h00

// reset values
`define SIOM_OUT1_SEL_RST 7'h09
`define SIOM_OUT2_SEL_RST 7'h0d
`define SIOM_OUT3_SEL_RST 7'h00
`define SIOM_MASK_RST     6'h00
`define SIOM_POL_RST      1'b0
`define SIOM_CODE_RST     5'h00

// input function codes with special handling
`define SIOM_FN_NONE      5'h00
`define SIOM_FN_ENABLE    1
`define SIOM_FN_DRV_RST   2
`define SIOM_FN_PROG_RST  14
`define SIOM_FN_ENC_CLR   15

`endif

/* logic/siom_top.v */
// servo i/o terminal function mapping with apb register access
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "siom_defs.vh"

module siom_top
(
	input  wire                            clk,
	input  wire                            rst_n,
	input  wire                            psel,
	input  wire                            penable,
	input  wire                            pwrite,
	input  wire [11:0]                     paddr,
	input  wire [31:0]                     pwdata,
	output wire                            pready,
	output reg  [31:0]                     prdata,
	output reg                             pslverr,
	input  wire [`SIOM_OUT_FUNCS-1:0]      out_function_active,
	input  wire [2:0]                      out_hi_function_active,
	output reg  [`SIOM_OUT_N-1:0]          digital_output_pin,
	input  wire [`SIOM_IN_N-1:0]           digital_input_terminal,
	output reg  [`SIOM_FUNC_N:1]           input_function_level,
	output reg                             drive_reset_pulse,
	output reg                             prog_reset_pulse,
	output reg                             encoder_clear_pulse
);

////////////////////////////////////////////////////////////////////////////////
// reset release

// two flops so every register leaves reset on the same edge
reg  sync_rst_a_n;
reg  sync_rst_n;

always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		sync_rst_a_n <= 1'b0;
		sync_rst_n   <= 1'b0;
	end
	else
	begin
		sync_rst_a_n <= 1'b1;
		sync_rst_n   <= sync_rst_a_n;
	end
end

////////////////////////////////////////////////////////////////////////////////
// register storage

reg  [`SIOM_SEL_W-1:0]   out_sel [0:`SIOM_OUT_SEL_N-1];
reg  [`SIOM_OUT_N-1:0]   output_force_mask;
reg  [2:0]               out_polarity;
reg                      force_enable;
reg  [`SIOM_CODE_W-1:0]  input_function_code [0:`SIOM_IN_N-1];
reg  [`SIOM_OUT_N-1:0]   output_terminal_status;

wire                     setup_phase;
wire                     write_take;
wire                     in_code_hit;
wire [11:0]              in_code_off;
wire [`SIOM_IDX_W-1:0]   in_code_idx;
wire                     sel_range_ok;
wire                     sel_wr_bad;
wire                     addr_aligned;
wire                     hit_out1_sel;
wire                     hit_out2_sel;
wire                     hit_out3_sel;
wire                     hit_out_status;
wire                     hit_force_mask;
wire                     hit_out1_pol;
wire                     hit_out2_pol;
wire                     hit_out3_pol;
wire                     hit_force_ctrl;
wire                     hit_in_status;
wire [`SIOM_SEL_W-1:0]   wr_sel;
wire [`SIOM_OUT_N-1:0]   wr_mask;
wire                     wr_flag;
wire [`SIOM_CODE_W-1:0]  wr_code;

assign setup_phase    = psel & ~penable;
assign write_take     = psel & penable & pwrite;
assign pready         = 1'b1;

// register address decode
assign addr_aligned   = (paddr[`SIOM_ALIGN_W-1:0] == {`SIOM_ALIGN_W{1'b0}});
assign hit_out1_sel   = (paddr == `SIOM_OFS_OUT1_SEL);
assign hit_out2_sel   = (paddr == `SIOM_OFS_OUT2_SEL);
assign hit_out3_sel   = (paddr == `SIOM_OFS_OUT3_SEL);
assign hit_out_status = (paddr == `SIOM_OFS_OUT_STATUS);
assign hit_force_mask = (paddr == `SIOM_OFS_FORCE_MASK);
assign hit_out1_pol   = (paddr == `SIOM_OFS_OUT1_POL);
assign hit_out2_pol   = (paddr == `SIOM_OFS_OUT2_POL);
assign hit_out3_pol   = (paddr == `SIOM_OFS_OUT3_POL);
assign hit_force_ctrl = (paddr == `SIOM_OFS_FORCE_CTRL);
assign hit_in_status  = (paddr == `SIOM_OFS_IN_STATUS);
assign in_code_hit    = (paddr >= `SIOM_OFS_IN_CODE_BASE) && (paddr <= `SIOM_OFS_IN_CODE_LAST)
	&& addr_aligned;
assign in_code_off    = paddr - `SIOM_OFS_IN_CODE_BASE;
assign in_code_idx    = in_code_off[`SIOM_IDX_W+`SIOM_ALIGN_W-1:`SIOM_ALIGN_W];

// write data fields
assign wr_sel         = pwdata[`SIOM_SEL_W-1:0];
assign wr_mask        = pwdata[`SIOM_OUT_N-1:0];
assign wr_flag        = pwdata[`SIOM_FLAG_BIT];
assign wr_code        = pwdata[`SIOM_CODE_W-1:0];
// selector writes above 99 are refused and leave the old value
assign sel_range_ok   = (pwdata[31:`SIOM_SEL_W] == 25'h0000000)
	&& (wr_sel <= `SIOM_SEL_MAX);
assign sel_wr_bad     = pwrite & ~sel_range_ok;

integer k;

always @(posedge clk or negedge sync_rst_n)
begin
	if (!sync_rst_n)
	begin
		out_sel[0]        <= `SIOM_OUT1_SEL_RST;
		out_sel[1]        <= `SIOM_OUT2_SEL_RST;
		out_sel[2]        <= `SIOM_OUT3_SEL_RST;
		output_force_mask <= `SIOM_MASK_RST;
		out_polarity      <= {3{`SIOM_POL_RST}};
		force_enable      <= 1'b0;
		for (k = 0; k < `SIOM_IN_N; k = k + 1)
			input_function_code[k] <= `SIOM_CODE_RST;
	end
	else if (write_take)
	begin
		if (hit_out1_sel)
		begin
			if (sel_range_ok)
				out_sel[0] <= wr_sel;
		end
		else if (hit_out2_sel)
		begin
			if (sel_range_ok)
				out_sel[1] <= wr_sel;
		end
		else if (hit_out3_sel)
		begin
			if (sel_range_ok)
				out_sel[2] <= wr_sel;
		end
		else if (hit_force_mask)
			output_force_mask <= wr_mask;
		else if (hit_out1_pol)
			out_polarity[0] <= wr_flag;
		else if (hit_out2_pol)
			out_polarity[1] <= wr_flag;
		else if (hit_out3_pol)
			out_polarity[2] <= wr_flag;
		else if (hit_force_ctrl)
			force_enable <= wr_flag;
		else if (in_code_hit)
			input_function_code[in_code_idx] <= wr_code;
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb read and error decode, captured in the setup cycle

reg  [31:0]  next_prdata;
reg          next_pslverr;

always @*
begin
	next_prdata  = 32'h00000000;
	next_pslverr = 1'b0;
	if (hit_out1_sel)
	begin
		next_prdata[`SIOM_SEL_W-1:0] = out_sel[0];
		next_pslverr = sel_wr_bad;
	end
	else if (hit_out2_sel)
	begin
		next_prdata[`SIOM_SEL_W-1:0] = out_sel[1];
		next_pslverr = sel_wr_bad;
	end
	else if (hit_out3_sel)
	begin
		next_prdata[`SIOM_SEL_W-1:0] = out_sel[2];
		next_pslverr = sel_wr_bad;
	end
	else if (hit_out_status)
	begin
		next_prdata[`SIOM_OUT_N-1:0] = output_terminal_status;
		next_pslverr = pwrite;
	end
	else if (hit_force_mask)
		next_prdata[`SIOM_OUT_N-1:0] = output_force_mask;
	else if (hit_out1_pol)
		next_prdata[`SIOM_FLAG_BIT] = out_polarity[0];
	else if (hit_out2_pol)
		next_prdata[`SIOM_FLAG_BIT] = out_polarity[1];
	else if (hit_out3_pol)
		next_prdata[`SIOM_FLAG_BIT] = out_polarity[2];
	else if (hit_force_ctrl)
		next_prdata[`SIOM_FLAG_BIT] = force_enable;
	else if (hit_in_status)
	begin
		next_prdata[`SIOM_FUNC_N-1:0] = input_function_level;
		next_pslverr = pwrite;
	end
	else if (in_code_hit)
		next_prdata[`SIOM_CODE_W-1:0] = input_function_code[in_code_idx];
	else
		next_pslverr = 1'b1;
end

always @(posedge clk or negedge sync_rst_n)
begin
	if (!sync_rst_n)
	begin
		prdata  <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else if (setup_phase)
	begin
		prdata  <= next_prdata;
		pslverr <= next_pslverr;
	end
end

////////////////////////////////////////////////////////////////////////////////
// output terminals

wire [`SIOM_OUT_N-1:0]  func_on;
wire [`SIOM_OUT_N-1:0]  pin_level;

genvar g;

generate
	for (g = 0; g < `SIOM_OUT_N; g = g + 1)
	begin : out_term
		wire normal_on;
		if (g < `SIOM_OUT_SEL_N)
		begin : sel_term
			// selector 0 is no function
			assign normal_on = (out_sel[g] != `SIOM_SEL_NONE) & out_function_active[out_sel[g]];
			assign pin_level[g] = out_polarity[g] ? func_on[g] : ~func_on[g];
		end
		else
		begin : fix_term
			assign normal_on    = out_hi_function_active[g-`SIOM_OUT_SEL_N];
			assign pin_level[g] = func_on[g];
		end
		assign func_on[g] = force_enable ? output_force_mask[g] : normal_on;
	end
endgenerate

always @(posedge clk or negedge sync_rst_n)
begin
	if (!sync_rst_n)
	begin
		output_terminal_status <= {`SIOM_OUT_N{1'b0}};
		digital_output_pin     <= {`SIOM_OUT_N{1'b0}};
	end
	else
	begin
		// status is the function state, polarity only acts at the pin
		output_terminal_status <= func_on;
		digital_output_pin     <= pin_level;
	end
end

////////////////////////////////////////////////////////////////////////////////
// input terminals

reg  [`SIOM_IN_N-1:0]     in_state;
reg  [`SIOM_FUNC_N:1]     level_prev;
wire [`SIOM_FUNC_N:1]     next_level;

always @(posedge clk or negedge sync_rst_n)
begin
	if (!sync_rst_n)
		in_state <= {`SIOM_IN_N{1'b0}};
	else
		in_state <= digital_input_terminal;
end

// one decoder per function: or of every terminal carrying its code
// codes 0 and 25 to 31 match no decoder
generate
	for (g = 1; g <= `SIOM_FUNC_N; g = g + 1)
	begin : in_func
		localparam [`SIOM_CODE_W-1:0] fn_code = g;
		reg hit;
		integer t;
		always @*
		begin
			hit = 1'b0;
			for (t = 0; t < `SIOM_IN_N; t = t + 1)
				if (input_function_code[t] == fn_code)
					hit = hit | in_state[t];
		end
		assign next_level[g] = hit;
	end
endgenerate

always @(posedge clk or negedge sync_rst_n)
begin
	if (!sync_rst_n)
	begin
		input_function_level <= {`SIOM_FUNC_N{1'b0}};
		level_prev           <= {`SIOM_FUNC_N{1'b0}};
		drive_reset_pulse    <= 1'b0;
		prog_reset_pulse     <= 1'b0;
		encoder_clear_pulse  <= 1'b0;
	end
	else
	begin
		// level functions follow the terminal while it is high
		input_function_level <= next_level;
		level_prev           <= input_function_level;
		drive_reset_pulse    <= input_function_level[`SIOM_FN_DRV_RST]
			& ~level_prev[`SIOM_FN_DRV_RST];
		prog_reset_pulse     <= input_function_level[`SIOM_FN_PROG_RST]
			& ~level_prev[`SIOM_FN_PROG_RST];
		encoder_clear_pulse  <= input_function_level[`SIOM_FN_ENC_CLR]
			& ~level_prev[`SIOM_FN_ENC_CLR];
	end
end

endmodule

/* tb/siom_top_properties.sv */
// port assertions for the i/o function mapping block
`timescale 1ns/1ps
module siom_top_props
(
	input wire        clk,
	input wire        rst_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire [9:0]  digital_input_terminal,
	input wire [24:1] input_function_level,
	input wire        drive_reset_pulse,
	input wire        prog_reset_pulse,
	input wire        encoder_clear_pulse
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire rd_setup = psel && !penable && !pwrite;
property p_enc;
	encoder_clear_pulse |-> $past(input_function_level[15]) && !$past(input_function_level[15], 2);
endproperty
a_enc: assert property (p_enc) else $error("encoder clear without rising level");
property p_drv;
	drive_reset_pulse |-> $past(input_function_level[2]) && !$past(input_function_level[2], 2);
endproperty
a_drv: assert property (p_drv) else $error("drive reset without rising level");
property p_prg;
	prog_reset_pulse |-> $past(input_function_level[14]) && !$past(input_function_level[14], 2);
endproperty
a_prg: assert property (p_prg) else $error("download reset without rising level");
property p_one;
	encoder_clear_pulse |=> !encoder_clear_pulse;
endproperty
a_one: assert property (p_one) else $error("action pulse longer than one cycle");
property p_nofn;
	(|input_function_level) |-> (|$past(digital_input_terminal, 2));
endproperty
a_nofn: assert property (p_nofn) else $error("function on with all terminals low");
property p_range;
	psel && !penable && pwrite && paddr == 12'h000 && pwdata > 32'h63 |=> pslverr;
endproperty
a_range: assert property (p_range) else $error("selector above range accepted");
property p_sel;
	rd_setup && paddr == 12'h000 |=> prdata <= 32'h63 && !pslverr;
endproperty
a_sel: assert property (p_sel) else $error("selector read out of range");
property p_stat;
	rd_setup && paddr == 12'h00c |=> prdata[31:6] == 26'h0 && !pslverr;
endproperty
a_stat: assert property (p_stat) else $error("output status read bad");
property p_in;
	rd_setup && paddr == 12'h024 |=> prdata == {8'h00, $past(input_function_level)};
endproperty
a_in: assert property (p_in) else $error("input status differs from levels");
endmodule
bind siom_top siom_top_props u_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pslverr, .digital_input_terminal, .input_function_level, .drive_reset_pulse,
	.prog_reset_pulse, .encoder_clear_pulse);

/* tb/siom_switches.sv */
// switch bank model driving the input terminals
`timescale 1ns/1ps
module siom_switches
(
	input  wire       clk,
	input  wire [9:0] want,
	output reg  [9:0] term
);
initial term = 10'h000;
always @(posedge clk)
	term <= want;
endmodule

/* tb/siom_top_tb.sv */
// self-checking bench for the i/o function mapping block
`timescale 1ns/1ps
`include "siom_defs.vh"
module siom_top_tb;
reg          clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
reg  [11:0]  paddr = 0;
reg  [31:0]  pwdata = 0, rd;
reg  [99:0]  fn_act = 0;
reg  [2:0]   hi_act = 0;
reg  [9:0]   want = 0;
wire [9:0]   term;
wire         pready, pslverr, drv_p, prg_p, enc_p;
wire [31:0]  prdata;
wire [5:0]   pins;
wire [24:1]  lvl;
integer      fail_count = 0, cmp_count = 0, cyc = 0, n_drv = 0, n_prg = 0, n_enc = 0, c;
siom_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.out_function_active(fn_act), .out_hi_function_active(hi_act), .digital_output_pin(pins),
	.digital_input_terminal(term), .input_function_level(lvl), .drive_reset_pulse(drv_p),
	.prog_reset_pulse(prg_p), .encoder_clear_pulse(enc_p));
siom_switches u_sw (.clk(clk), .want(want), .term(term));
always #25 clk = ~clk;
////////////////////////////////////////////////////////////////
task wrap_up;
begin
	$display("compares %0d mismatches %0d", cmp_count, fail_count);
	if (fail_count == 0 && cmp_count > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
end
endtask
always @(posedge clk)
begin
	cyc <= cyc + 1;
	n_drv <= n_drv + drv_p;
	n_prg <= n_prg + prg_p;
	n_enc <= n_enc + enc_p;
	if (cyc == 4000)
	begin
		fail_count = fail_count + 1;
		wrap_up;
	end
end
task chk(input [31:0] got, input [31:0] exp);
begin
	cmp_count = cmp_count + 1;
	if (got !== exp)
	begin
		fail_count = fail_count + 1;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	end
end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
begin
	@(posedge clk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk);
	penable <= 1'b1;
	@(posedge clk);
	while (pready !== 1'b1)
		@(posedge clk);
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
end
endtask
task rchk(input w, input [11:0] a, input [31:0] d, input [31:0] exp, input e);
begin
	apb(w, a, d);
	if (!w)
		chk(rd, exp);
	chk({31'h0, err}, {31'h0, e});
end
endtask
////////////////////////////////////////////////////////////////
task t_reset;
begin
	rchk(0, `SIOM_OFS_OUT1_SEL, 0, 32'h9, 0);
	rchk(0, `SIOM_OFS_OUT2_SEL, 0, 32'hd, 0);
	rchk(0, `SIOM_OFS_OUT3_SEL, 0, 32'h0, 0);
	rchk(0, `SIOM_OFS_FORCE_MASK, 0, 32'h0, 0);
	rchk(0, `SIOM_OFS_OUT1_POL, 0, 32'h0, 0);
	chk({26'h0, pins}, 32'h7);
end
endtask
task t_select;
begin
	rchk(1, `SIOM_OFS_OUT1_SEL, 32'h63, 0, 0);
	rchk(1, `SIOM_OFS_OUT1_SEL, 32'h64, 0, 1);
	rchk(0, `SIOM_OFS_OUT1_SEL, 0, 32'h63, 0);
	rchk(1, `SIOM_OFS_OUT_STATUS, 32'h3f, 0, 1);
	rchk(0, 12'h100, 0, 32'h0, 1);
	rchk(1, `SIOM_OFS_OUT1_SEL, 32'h9, 0, 0);
	fn_act[9] <= 1'b1;
	hi_act <= 3'h4;
	rchk(0, `SIOM_OFS_OUT_STATUS, 0, 32'h21, 0);
	chk({26'h0, pins}, 32'h26);
	rchk(1, `SIOM_OFS_OUT1_POL, 32'h1, 0, 0);
	repeat (2) @(posedge clk);
	chk({26'h0, pins}, 32'h27);
end
endtask
task t_force;
begin
	rchk(1, `SIOM_OFS_FORCE_CTRL, 32'h1, 0, 0);
	rchk(1, `SIOM_OFS_FORCE_MASK, 32'h2a, 0, 0);
	rchk(0, `SIOM_OFS_OUT_STATUS, 0, 32'h2a, 0);
	chk({26'h0, pins}, 32'h2c);
	rchk(1, `SIOM_OFS_FORCE_CTRL, 32'h0, 0, 0);
end
endtask
task t_inputs;
begin
	for (c = 1; c <= 31; c = c + 1)
	begin
		rchk(1, `SIOM_OFS_IN_CODE_BASE, c, 0, 0);
		want <= 10'h003;
		repeat (4) @(posedge clk);
		rchk(0, `SIOM_OFS_IN_STATUS, 0, (c > `SIOM_FUNC_N) ? 0 : 32'h1 << (c - 1), 0);
		chk({8'h00, lvl}, (c > `SIOM_FUNC_N) ? 0 : 32'h1 << (c - 1));
		want <= 10'h002;
		repeat (4) @(posedge clk);
	end
	chk(n_drv, 1);
	chk(n_prg, 1);
	rchk(1, `SIOM_OFS_IN_CODE_BASE, 32'hf, 0, 0);
	want <= 10'h001;
	repeat (3) @(posedge clk);
	want <= 10'h000;
	repeat (3) @(posedge clk);
	want <= 10'h001;
	repeat (8) @(posedge clk);
	chk(n_enc, 3);
end
endtask
initial
begin
	repeat (16) @(posedge clk);
	rst_n <= 1'b1;
	repeat (4) @(posedge clk);
	t_reset;
	t_select;
	t_force;
	t_inputs;
	wrap_up;
end
endmodule
